/* File: core/tcp_timer.sv */
// timer with clear-on-match, fast and phase correct waveform modes
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`include "tcp_regs.svh"
`default_nettype none
module tcp_timer
    import tcp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // waveform pins
    output logic wave_out_a,
    output logic wave_out_a_oe,
    output logic wave_out_b,
    output logic wave_out_b_oe
);

    // software visible control
    logic [2:0] waveform_mode_sel; // full three-bit mode
    logic top_select_bit; // upper mode bit
    logic [1:0] mode_lo_reg; // lower mode bits
    logic [2:0] presc_sel_reg; // prescaler select
    logic [1:0] pin_dir_reg; // pin direction, 1 = output
    tcp_chan_s chan_reg [2]; // channel A = 0, channel B = 1
    logic [7:0] counter_value; // the counter itself
    logic count_up_reg; // phase correct direction
    logic overflow_flag; // overflow flag
    logic compare_flag_a; // compare A flag
    logic compare_flag_b; // compare B flag
    logic [1:0] oc_reg; // internal waveform output state

    // bus handshake
    tcp_bus_e bus_state;
    logic wr_take; // write takes effect this edge
    logic [2:0] flag_clr; // write one to clear
    logic [7:0] wbyte; // low write byte

    // prescaler
    logic [9:0] presc_cnt;
    logic [9:0] presc_mask;
    logic presc_on;
    logic tick; // timer clock enable

    // mode decode
    logic is_ctc;
    logic is_fast;
    logic is_pc;
    logic is_pwm;
    logic [7:0] top_val;
    logic at_top;
    logic [7:0] cmp_eff [2]; // compare value in use
    logic [1:0] match;
    logic reload; // buffered compare values load now
    logic [7:0] cnt_next;
    logic dir_next;
    logic ovf_set;

    assign waveform_mode_sel = {top_select_bit, mode_lo_reg};
    assign wbyte = writedata[7:0];

    // ---------------- bus slave ----------------

    // one wait cycle, then waitrequest drops for one cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus_state <= TCP_BUS_IDLE;
            waitrequest <= 1'b1;
        end else begin
            unique case (bus_state)
                // a request seen: answer next cycle
                TCP_BUS_IDLE: begin
                    if (read || write) begin
                        bus_state <= TCP_BUS_ACK;
                        waitrequest <= 1'b0;
                    end
                end
                // master samples the answer now
                TCP_BUS_ACK: begin
                    bus_state <= TCP_BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // write lands on the edge the master sees waitrequest low
    assign wr_take = write && !waitrequest && byteenable[0];

    // read data captured as waitrequest drops
    always_ff @(posedge mclk) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (read && bus_state == TCP_BUS_IDLE) begin
            readdata <= 32'h0000_0000;
            unique case (address)
                `TCP_OFS_CTRL_A: begin
                    readdata[7:0] <= {chan_reg[0].action,
                        chan_reg[1].action, 2'b00, mode_lo_reg};
                end
                `TCP_OFS_CTRL_B: begin
                    readdata[7:0] <= {4'h0, top_select_bit,
                        presc_sel_reg};
                end
                `TCP_OFS_COUNT: begin
                    readdata[7:0] <= counter_value;
                end
                `TCP_OFS_CMP_A: begin
                    readdata[7:0] <= chan_reg[0].cmp_buf;
                end
                `TCP_OFS_CMP_B: begin
                    readdata[7:0] <= chan_reg[1].cmp_buf;
                end
                `TCP_OFS_FLAGS: begin
                    readdata[7:0] <= {5'h00, compare_flag_b,
                        compare_flag_a, overflow_flag};
                end
                `TCP_OFS_PIN_DIR: begin
                    readdata[7:0] <= {6'h00, pin_dir_reg};
                end
                // unmapped addresses read zero
                default: begin
                    readdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // control register writes
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_lo_reg <= 2'h0;
            top_select_bit <= 1'b0;
            presc_sel_reg <= 3'h0;
            pin_dir_reg <= 2'h0;
            chan_reg[0].action <= 2'h0;
            chan_reg[1].action <= 2'h0;
        end else if (wr_take) begin
            // action fields act at once, no buffering
            if (address == `TCP_OFS_CTRL_A) begin
                chan_reg[0].action <= wbyte[`TCP_ACT_A_POS +: 2];
                chan_reg[1].action <= wbyte[`TCP_ACT_B_POS +: 2];
                mode_lo_reg <= wbyte[`TCP_MODE_LO_POS +: 2];
            end
            if (address == `TCP_OFS_CTRL_B) begin
                top_select_bit <= wbyte[`TCP_TOP_SEL_POS];
                presc_sel_reg <= wbyte[`TCP_PRESC_POS +: 3];
            end
            if (address == `TCP_OFS_PIN_DIR) begin
                pin_dir_reg <= wbyte[1:0];
            end
        end
    end

    // flag clear mask from a write of ones
    assign flag_clr = (wr_take && address == `TCP_OFS_FLAGS) ?
        wbyte[2:0] : 3'h0;

    // ---------------- prescaler ----------------

    // select code picks the divide mask; others stop the timer
    always_comb begin
        presc_on = 1'b1;
        presc_mask = `TCP_DIV1_MASK;
        unique case (presc_sel_reg)
            3'h1: presc_mask = `TCP_DIV1_MASK;
            3'h2: presc_mask = `TCP_DIV8_MASK;
            3'h3: presc_mask = `TCP_DIV64_MASK;
            3'h4: presc_mask = `TCP_DIV256_MASK;
            3'h5: presc_mask = `TCP_DIV1024_MASK;
            default: presc_on = 1'b0;
        endcase
    end

    // free running divider count
    always_ff @(posedge mclk) begin
        if (reset) begin
            presc_cnt <= 10'h000;
        end else begin
            presc_cnt <= presc_cnt + 10'h001;
        end
    end

    // one-cycle enable every N clocks
    assign tick = presc_on && ((presc_cnt & presc_mask) == presc_mask); // RULE21

    // ---------------- counter ----------------

    // mode decode and top selection
    always_comb begin
        is_ctc = (waveform_mode_sel == `TCP_MODE_CTC); // RULE1
        is_fast = (waveform_mode_sel == `TCP_MODE_FAST_FF) ||
            (waveform_mode_sel == `TCP_MODE_FAST_CMP); // RULE7
        is_pc = (waveform_mode_sel == `TCP_MODE_PC_FF) ||
            (waveform_mode_sel == `TCP_MODE_PC_CMP); // RULE14
        is_pwm = is_fast || is_pc;
        // pwm top: fixed max or compare A
        top_val = top_select_bit ? chan_reg[0].cmp_act : `TCP_MAX; // RULE7 RULE14
        // clear-on-match uses compare A straight from software
        if (is_ctc) begin
            top_val = chan_reg[0].cmp_buf; // RULE2
        end
        at_top = (counter_value == top_val);
    end

    // compare values: buffered in pwm, direct otherwise
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmp_eff[i] = is_pwm ? chan_reg[i].cmp_act : chan_reg[i].cmp_buf; // RULE13
            match[i] = (counter_value == cmp_eff[i]);
        end
    end

    // buffered values load when the counter sits at top
    assign reload = is_pwm && tick && at_top; // RULE13

    // next count, direction and overflow event
    always_comb begin
        cnt_next = counter_value;
        dir_next = count_up_reg;
        ovf_set = 1'b0;
        if (is_ctc) begin
            // missed top simply wraps through max
            cnt_next = at_top ? `TCP_BOTTOM : counter_value + 8'h01; // RULE1 RULE2
            ovf_set = (counter_value == `TCP_MAX); // RULE5
        end else if (is_fast) begin
            // clear on the timer cycle after top
            cnt_next = at_top ? `TCP_BOTTOM : counter_value + 8'h01; // RULE8
            ovf_set = at_top; // RULE9
        end else if (is_pc) begin
            if (count_up_reg) begin
                // top held one timer cycle, then turn down
                if (at_top) begin
                    dir_next = 1'b0; // RULE15
                    cnt_next = (top_val == `TCP_BOTTOM) ? `TCP_BOTTOM :
                        counter_value - 8'h01;
                end else begin
                    cnt_next = counter_value + 8'h01;
                end
            end else if (counter_value == `TCP_BOTTOM) begin
                // bottom turns back up and flags overflow
                dir_next = 1'b1;
                ovf_set = 1'b1; // RULE16
                cnt_next = (top_val == `TCP_BOTTOM) ? `TCP_BOTTOM :
                    8'h01;
            end else begin
                cnt_next = counter_value - 8'h01;
            end
        end else begin
            // plain up count with wrap
            cnt_next = counter_value + 8'h01;
            ovf_set = (counter_value == `TCP_MAX);
        end
    end

    // counter moves only on the timer clock enable
    always_ff @(posedge mclk) begin
        if (reset) begin
            counter_value <= `TCP_BOTTOM;
            count_up_reg <= 1'b1;
        end else if (tick) begin
            counter_value <= cnt_next; // RULE23
            count_up_reg <= is_pc ? dir_next : 1'b1;
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            overflow_flag <= 1'b0;
            compare_flag_a <= 1'b0;
            compare_flag_b <= 1'b0;
        end else begin
            overflow_flag <= (overflow_flag && !flag_clr[`TCP_FLG_OVF]) ||
                (tick && ovf_set); // RULE5 RULE9 RULE16
            compare_flag_a <= (compare_flag_a &&
                !flag_clr[`TCP_FLG_CMPA]) || (tick && match[0]); // RULE6
            compare_flag_b <= (compare_flag_b &&
                !flag_clr[`TCP_FLG_CMPB]) || (tick && match[1]);
        end
    end

    // ---------------- compare channels ----------------

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            logic [7:0] cmp_wr_ofs; // this channel's offset
            logic toggle_ok; // toggle allowed in pwm
            logic up_eff; // direction seen by the comparator
            logic up_level; // level after an up-count match
            assign cmp_wr_ofs = (ch == 0) ? {3'h0, `TCP_OFS_CMP_A} :
                {3'h0, `TCP_OFS_CMP_B};
            // toggle in pwm modes: channel A with top select only
            assign toggle_ok = (ch == 0) && top_select_bit; // RULE11 RULE18
            // bottom acts as up-count, top as down-count match
            assign up_eff = (counter_value == `TCP_BOTTOM) ? 1'b1 :
                at_top ? 1'b0 : count_up_reg; // RULE19
            // non-inverting clears on the way up
            assign up_level = chan_reg[ch].action[0]; // RULE17

            // software buffer and comparator copy
            always_ff @(posedge mclk) begin
                if (reset) begin
                    chan_reg[ch].cmp_buf <= `TCP_RST_BYTE;
                    chan_reg[ch].cmp_act <= `TCP_RST_BYTE;
                end else begin
                    if (wr_take && {3'h0, address} == cmp_wr_ofs) begin
                        chan_reg[ch].cmp_buf <= wbyte;
                    end
                    // pwm loads at top, other modes track at once
                    if (!is_pwm || reload) begin
                        chan_reg[ch].cmp_act <= chan_reg[ch].cmp_buf; // RULE13
                    end
                end
            end

            // waveform output state per mode and action
            always_ff @(posedge mclk) begin
                if (reset) begin
                    oc_reg[ch] <= 1'b0; // RULE22
                end else if (tick && chan_reg[ch].action != 2'h0) begin
                    if (!is_pwm) begin
                        // toggle, clear or set on match
                        if (match[ch]) begin
                            unique case (chan_reg[ch].action)
                                2'h1: oc_reg[ch] <= !oc_reg[ch]; // RULE3
                                2'h2: oc_reg[ch] <= 1'b0;
                                default: oc_reg[ch] <= 1'b1;
                            endcase
                        end
                    end else if (!chan_reg[ch].action[1]) begin
                        // action one: toggle where allowed
                        if (match[ch] && toggle_ok) begin
                            oc_reg[ch] <= !oc_reg[ch]; // RULE11 RULE18
                        end
                    end else if (is_fast) begin
                        // top restarts the period; match ignored there
                        if (at_top) begin
                            oc_reg[ch] <= !up_level; // RULE10 RULE12
                        end else if (match[ch]) begin
                            oc_reg[ch] <= up_level; // RULE10 RULE12
                        end
                    end else if (at_top && count_up_reg) begin
                        // top fixes the up-side level for the next
                        // compare value, giving the symmetry edge
                        oc_reg[ch] <= (chan_reg[ch].cmp_buf == top_val) ?
                            !up_level : up_level; // RULE20 RULE19
                    end else if (match[ch]) begin
                        // up match one level, down match the other
                        oc_reg[ch] <= up_eff ? up_level : !up_level; // RULE17
                    end
                end
            end
        end
    endgenerate

    // ---------------- pins ----------------

    // pin shows the state only when direction is output
    always_ff @(posedge mclk) begin
        if (reset) begin
            wave_out_a <= 1'b0;
            wave_out_a_oe <= 1'b0;
            wave_out_b <= 1'b0;
            wave_out_b_oe <= 1'b0;
        end else begin
            wave_out_a <= oc_reg[0] && pin_dir_reg[0]; // RULE4
            wave_out_a_oe <= pin_dir_reg[0] &&
                (chan_reg[0].action != 2'h0); // RULE4
            wave_out_b <= oc_reg[1] && pin_dir_reg[1]; // RULE4
            wave_out_b_oe <= pin_dir_reg[1] &&
                (chan_reg[1].action != 2'h0); // RULE4
        end
    end

    // ---------------- assertions ----------------

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // a top step in fast mode
    sequence fast_top_s;
        is_fast && tick && at_top;
    endsequence

    // reaching bottom while counting down
    sequence pc_bottom_s;
        is_pc && tick && !count_up_reg && counter_value == 8'h00;
    endsequence

    ctc_clear_a: assert property ( // RULE1
        is_ctc && tick && at_top |=> counter_value == 8'h00)
        else $error("counter not cleared at compare A");

    ctc_wrap_a: assert property ( // RULE5
        is_ctc && tick && counter_value == 8'hff && !at_top
        |=> counter_value == 8'h00 && overflow_flag)
        else $error("overflow not set on wrap");

    ctc_toggle_a: assert property ( // RULE3
        is_ctc && tick && match[0] && chan_reg[0].action == 2'h1
        |=> oc_reg[0] != $past(oc_reg[0]))
        else $error("channel A did not toggle");

    pin_hidden_a: assert property ( // RULE4
        !pin_dir_reg[0] |=> !wave_out_a_oe && !wave_out_a)
        else $error("pin driven while input");

    fast_restart_a: assert property ( // RULE8
        fast_top_s |=> counter_value == 8'h00 && overflow_flag)
        else $error("fast mode did not restart after top");

    pc_turn_a: assert property ( // RULE15
        is_pc && tick && count_up_reg && at_top && top_val != 8'h00
        |=> !count_up_reg && counter_value == $past(top_val) - 8'h01)
        else $error("no reversal at top");

    pc_overflow_a: assert property ( // RULE16
        pc_bottom_s |=> overflow_flag && count_up_reg)
        else $error("overflow not set at bottom");

    count_hold_a: assert property ( // RULE23
        !tick |=> $stable(counter_value))
        else $error("counter moved without enable");

    fast_non_inv_a: assert property ( // RULE10
        (fast_top_s and (chan_reg[0].action == 2'h2)) |=> oc_reg[0])
        else $error("fast output not set at bottom");

    // at top the output takes the up-match level of the next compare
    pc_symmetry_a: assert property ( // RULE20
        is_pc && tick && count_up_reg && at_top &&
        chan_reg[0].action == 2'h2 && chan_reg[0].cmp_buf != top_val
        |=> !oc_reg[0])
        else $error("no symmetry level at top");

endmodule : tcp_timer
`default_nettype wire

/* File: core/tcp_regs.svh */
// register offsets, field positions, reset values and timing counts
//
// Contract
// [RULE1] mode 2 clears counter at compare A
// [RULE2] mode 2 compare A unbuffered, late top wraps
// [RULE3] mode 2 action 1 toggles channel A
// [RULE4] pin driven only when direction is output
// [RULE5] mode 2 overflow set on MAX to zero
// [RULE6] mode 2 compare A flag at top
// [RULE7] modes 3 and 7 single slope, top selectable
// [RULE8] fast PWM clears counter after top
// [RULE9] fast PWM overflow flag at top
// [RULE10] fast PWM action 2 non-inverting, 3 inverting
// [RULE11] fast PWM action 1 toggles A only
// [RULE12] fast PWM extreme compare values handled
// [RULE13] fast PWM compare registers double buffered
// [RULE14] modes 1 and 5 dual slope, top selectable
// [RULE15] phase correct reverses at top, one cycle
// [RULE16] phase correct overflow flag at bottom
// [RULE17] phase correct up clears, down sets
// [RULE18] phase correct action 1 toggles A only
// [RULE19] phase correct extreme compare values constant
// [RULE20] phase correct symmetry transitions without match
// [RULE21] prescaler 1, 8, 64, 256, 1024
// [RULE22] reset clears waveform output state
// [RULE23] eight bit counter advances on enable only
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH
// byte offsets of the register words
`define TCP_OFS_CTRL_A 5'h00
`define TCP_OFS_CTRL_B 5'h04
`define TCP_OFS_COUNT 5'h08
`define TCP_OFS_CMP_A 5'h0c
`define TCP_OFS_CMP_B 5'h10
`define TCP_OFS_FLAGS 5'h14
`define TCP_OFS_PIN_DIR 5'h18
// control A fields
`define TCP_ACT_A_POS 6
`define TCP_ACT_B_POS 4
`define TCP_MODE_LO_POS 0
// control B fields
`define TCP_TOP_SEL_POS 3
`define TCP_PRESC_POS 0
// flag positions
`define TCP_FLG_OVF 0
`define TCP_FLG_CMPA 1
`define TCP_FLG_CMPB 2
// reset values
`define TCP_RST_BYTE 8'h00
// mode codes of the three-bit mode field
`define TCP_MODE_NORMAL 3'h0
`define TCP_MODE_PC_FF 3'h1
`define TCP_MODE_CTC 3'h2
`define TCP_MODE_FAST_FF 3'h3
`define TCP_MODE_PC_CMP 3'h5
`define TCP_MODE_FAST_CMP 3'h7
// counter limits
`define TCP_MAX 8'hff
`define TCP_BOTTOM 8'h00
// prescaler divide masks, divider minus one
`define TCP_DIV1_MASK 10'h000
`define TCP_DIV8_MASK 10'h007
`define TCP_DIV64_MASK 10'h03f
`define TCP_DIV256_MASK 10'h0ff
`define TCP_DIV1024_MASK 10'h3ff
`endif

/* File: core/tcp_pkg.sv */
// types shared by the timer waveform block
`default_nettype none
package tcp_pkg;
    // bus slave handshake states, one-hot
    typedef enum logic [1:0] {
        TCP_BUS_IDLE = 2'b01,
        TCP_BUS_ACK = 2'b10
    } tcp_bus_e;
    // per channel configuration carried together
    typedef struct packed {
        logic [1:0] action; // output action field
        logic [7:0] cmp_buf; // value software wrote
        logic [7:0] cmp_act; // value the comparator uses
    } tcp_chan_s;
endpackage : tcp_pkg
`default_nettype wire

/* File: bench/tcp_tb.sv */
// self-checking bench for the timer waveform block
`include "tcp_regs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and bus
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    // waveform pins
    logic wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
    // bookkeeping
    int n_fail = 0;
    int checked = 0;
    logic [31:0] rd;
    int v;
    int k;
    // scenario tables: control A, control B, compare, expectation
    logic [7:0] t_ca[11] = '{8'h83, 8'hc3, 8'h83, 8'h83, 8'h81, 8'hc1,
        8'h81, 8'h81, 8'h43, 8'h43, 8'h41};
    logic [7:0] t_cb[11] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h01, 8'h09, 8'h01, 8'h09};
    logic [7:0] t_cm[11] = '{8'h40, 8'h40, 8'hff, 8'h00, 8'h40, 8'h40,
        8'h00, 8'hff, 8'h03, 8'h03, 8'h10};
    int t_ex[11] = '{65, 191, 256, 1, 128, 382, 0, 510, 4, -1, 32};
    int divs[5] = '{1, 8, 64, 256, 1024};
    // device under test
    tcp_timer dut_u (.mclk(mclk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .wave_out_a(wave_out_a),
        .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
        .wave_out_b_oe(wave_out_b_oe));
    // 50 MHz clock
    initial begin
        forever #10 mclk = ~mclk;
    end
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    // compare one value and count it
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one avalon transfer: request held until waitrequest is sampled low
    // at a rising edge; read data taken at that edge, then released
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // one idle edge so the next call never re-drives in this step
        @(posedge mclk);
        if (n >= 50) begin
            check("bus answer", 32'h1, 32'h0);
            close_out();
        end
    endtask : bus
    // register write
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    // set up a mode, let it settle, then clear the flags
    task automatic cfg(input logic [7:0] ca, input logic [7:0] cb,
        input logic [7:0] cm);
        wr(`TCP_OFS_CMP_A, cm);
        wr(`TCP_OFS_CTRL_A, ca);
        wr(`TCP_OFS_CTRL_B, cb);
        repeat (600) @(posedge mclk);
        wr(`TCP_OFS_FLAGS, 8'h07);
    endtask : cfg
    // cycles between two transitions of pin a, -1 if none seen
    task automatic gap(output int n);
        logic last;
        int i;
        int t0;
        n = -1;
        t0 = -1;
        last = wave_out_a;
        for (i = 0; i < 3000 && n < 0; i++) begin
            @(negedge mclk);
            if (wave_out_a !== last) begin
                if (t0 >= 0) n = i - t0;
                t0 = i;
            end
            last = wave_out_a;
        end
        @(posedge mclk);
    endtask : gap
    // high cycles of pin a over a window
    task automatic highs(input int len, output int h);
        h = 0;
        repeat (len) begin
            @(negedge mclk);
            if (wave_out_a === 1'b1) h++;
        end
        @(posedge mclk);
    endtask : highs
    // main sequence
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        // state after reset, unmapped offset reads zero
        check("pins", {28'h0, wave_out_a, wave_out_a_oe, wave_out_b,
            wave_out_b_oe}, 32'h0);
        bus(1'b0, `TCP_OFS_COUNT, 8'h00, rd);
        check("count", rd, 32'h0);
        bus(1'b0, 5'h1c, 8'h00, rd);
        check("unmapped", rd, 32'h0);
        wr(`TCP_OFS_PIN_DIR, 8'h01);
        // clear-on-match toggling at compare a
        cfg(8'h42, 8'h01, 8'h03);
        gap(v);
        check("ctc period", v, 4);
        bus(1'b0, `TCP_OFS_FLAGS, 8'h00, rd);
        check("cmp a flag", rd & 32'h2, 32'h2);
        // pin hidden while direction is input
        wr(`TCP_OFS_PIN_DIR, 8'h00);
        highs(40, v);
        check("hidden pin", v, 0);
        check("pin enable", {31'h0, wave_out_a_oe}, 32'h0);
        wr(`TCP_OFS_PIN_DIR, 8'h01);
        // top lowered below the running count
        cfg(8'h42, 8'h01, 8'hf0);
        k = 0;
        do begin
            bus(1'b0, `TCP_OFS_COUNT, 8'h00, rd);
            k++;
        end while ((rd[7:0] < 8'h40 || rd[7:0] > 8'hd0) && k < 200);
        check("poll limit", {31'h0, k < 200}, 32'h1);
        wr(`TCP_OFS_CMP_A, 8'h10);
        wr(`TCP_OFS_FLAGS, 8'h07);
        bus(1'b0, `TCP_OFS_COUNT, 8'h00, rd);
        check("missed top", {31'h0, rd[7:0] > 8'h3f}, 32'h1);
        repeat (300) @(posedge mclk);
        bus(1'b0, `TCP_OFS_FLAGS, 8'h00, rd);
        check("wrap overflow", rd & 32'h1, 32'h1);
        bus(1'b0, `TCP_OFS_COUNT, 8'h00, rd);
        check("new top", {31'h0, rd[7:0] <= 8'h10}, 32'h1);
        // prescale factors, match on every timer tick
        for (int i = 0; i < 5; i++) begin
            cfg(8'h42, 8'(i + 1), 8'h00);
            gap(v);
            check("tick spacing", v, divs[i]);
        end
        // duty in fast and phase correct modes, then toggle periods
        for (int i = 0; i < 11; i++) begin
            cfg(t_ca[i], t_cb[i], t_cm[i]);
            if (i < 8) begin
                highs((t_ca[i][1:0] == 2'b11) ? 256 : 510, v);
                check("duty", v, t_ex[i]);
                bus(1'b0, `TCP_OFS_FLAGS, 8'h00, rd);
                check("overflow", rd & 32'h1, 32'h1);
            end else begin
                gap(v);
                check("toggle", v, t_ex[i]);
            end
        end
        // a compare written mid-period waits for top in fast mode
        cfg(8'h83, 8'h01, 8'h40);
        k = 0;
        do begin
            bus(1'b0, `TCP_OFS_COUNT, 8'h00, rd);
            k++;
        end while ((rd[7:0] < 8'h10 || rd[7:0] > 8'h30) && k < 200);
        wr(`TCP_OFS_CMP_A, 8'h08);
        do begin
            bus(1'b0, `TCP_OFS_COUNT, 8'h00, rd);
            k++;
        end while ((rd[7:0] < 8'h48 || rd[7:0] > 8'hf0) && k < 400);
        check("buffered cmp", {31'h0, wave_out_a}, 32'h0);
        check("poll limit", {31'h0, k < 400}, 32'h1);
        // channel b enable follows its direction and action
        wr(`TCP_OFS_PIN_DIR, 8'h02);
        wr(`TCP_OFS_CTRL_A, 8'h20);
        repeat (2) @(posedge mclk);
        check("pin b enable", {30'h0, wave_out_b_oe, wave_out_a_oe},
            32'h2);
        close_out();
    end
endmodule : testbench
`default_nettype wire
